// ### result_status_params.svh
// Field positions, codes and reset values of the result status bytes
`ifndef RESULT_STATUS_PARAMS_SVH
`define RESULT_STATUS_PARAMS_SVH

// ****************************************
// Byte 0 fields
// ****************************************
`define RS0_TERM_HI        7
`define RS0_TERM_LO        6
`define RS0_POS_DONE       5
`define RS0_TRK0_FAULT     4
`define RS0_UNREADY        3
`define RS0_SIDE           2
`define TERM_NORMAL        2'h0
`define TERM_FAILED        2'h1
`define TERM_NOT_STARTED   2'h2

// ****************************************
// Byte 1 fields
// ****************************************
`define RS1_PAST_LAST      7
`define RS1_CRC_FAIL       5
`define RS1_OVERRUN        4
`define RS1_SECTOR_ABSENT  2
`define RS1_WRITE_BLOCKED  1
`define RS1_ID_SYNC        0
`define RS1_UNUSED_HI      6
`define RS1_UNUSED_LO      3

// ****************************************
// Byte 2 fields
// ****************************************
`define RS2_DELETED        6
`define RS2_DATA_CRC       5
`define RS2_CYL_MISMATCH   4
`define RS2_EQUAL_HIT      3
`define RS2_NO_HIT         2
`define RS2_BAD_TRACK      1
`define RS2_DATA_SYNC      0
`define RS2_UNUSED         7
`define BAD_CYLINDER_ID    8'hFF

// ****************************************
// Byte 3 fields and misc
// ****************************************
`define RS3_WP_HI          6
`define RS3_READY          5
`define RS3_TRK0           4
`define RS3_WP_LO          3
`define RS3_SIDE           2
`define DRIVE_LINE_RESET   8'h20
`define RECAL_STEP_LIMIT   7'h4D
`define STATUS_RESET       8'h00
`define BYTE_SEL_RESET     2'h0

`endif

// ### result_status_pkg.sv
// Types shared by the result status logic
package result_status_pkg;

  typedef enum logic [2:0] {
    CMD_READ_DATA,
    CMD_WRITE_DATA,
    CMD_WRITE_DELETED,
    CMD_READ_ID,
    CMD_READ_TRACK,
    CMD_FORMAT_TRACK,
    CMD_SCAN,
    CMD_OTHER
  } cmd_kind_t;

  // Events reported by the command sequencer, one-cycle pulses
  typedef struct packed {
    logic       past_last_sector;
    logic       id_crc_bad;
    logic       data_crc_bad;
    logic       overrun;
    logic       sector_not_found;
    logic       id_sync_missing;
    logic       data_sync_missing;
    logic       deleted_mark;
    logic       scan_equal;
    logic       scan_no_match;
    logic       medium_cyl_valid;
    logic [7:0] medium_cyl;
  } media_event_t;

  // Drive select lines driven by the controller
  typedef struct packed {
    logic       side;
    logic [1:0] unit;
  } drive_sel_t;

endpackage : result_status_pkg

// ### fdc_result_status.sv
// Result status bytes of the floppy controller and their read-out path
`include "result_status_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fdc_result_status #(
  parameter int unsigned STEP_W = 7
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // Command sequencer
  input  wire logic                          cmd_start_i,
  input  wire result_status_pkg::cmd_kind_t  cmd_kind_i,
  input  wire logic                          cmd_end_i,
  input  wire logic [1:0]                    term_code_i,
  input  wire logic                          seek_done_i,
  input  wire logic                          recal_start_i,
  input  wire logic                          step_pulse_i,
  input  wire logic                          irq_raise_i,
  input  wire result_status_pkg::media_event_t media_evt_i,
  input  wire logic [7:0]                    target_cyl_i,
  input  wire result_status_pkg::drive_sel_t drive_sel_i,
  // Result phase
  input  wire logic                          result_start_i,
  input  wire logic [1:0]                    result_first_i,
  input  wire logic [1:0]                    result_count_i,
  // Host data register port
  input  wire logic                          data_rd_i,
  output logic [7:0]                         data_o,
  output logic                               transfer_direction_o,
  output logic                               host_request_flag_o,
  output logic                               result_done_o,
  // Drive lines
  input  wire logic                          write_protect_i,
  input  wire logic                          track_zero_line_i,
  // Status byte views
  output logic [7:0]                         result_status_0_o,
  output logic [7:0]                         result_status_1_o,
  output logic [7:0]                         result_status_2_o,
  output logic [7:0]                         drive_line_status_o
);
  import result_status_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ****************************************
  // Command decoding
  // ****************************************
  function automatic logic is_write_cmd(input cmd_kind_t k);
    return (k == CMD_WRITE_DATA) || (k == CMD_WRITE_DELETED) || (k == CMD_FORMAT_TRACK);
  endfunction : is_write_cmd

  // Scan outcomes only mean something while a scan runs
  function automatic logic is_scan_cmd(input cmd_kind_t k);
    return (k == CMD_SCAN);
  endfunction : is_scan_cmd

  function automatic logic watches_deleted(input cmd_kind_t k);
    return (k == CMD_READ_DATA) || (k == CMD_SCAN);
  endfunction : watches_deleted

  // ****************************************
  // Recalibrate step counter
  // ****************************************
  logic              recal_reg, recal_next;
  logic [STEP_W-1:0] steps_reg, steps_next;
  logic              recal_fault;

  // Track zero beats a step in the same cycle: the head is already home
  always_comb begin
    recal_next  = recal_reg;
    steps_next  = steps_reg;
    recal_fault = 1'b0;
    if (recal_start_i) begin
      recal_next = 1'b1;
      steps_next = '0;
    end else if (recal_reg && track_zero_line_i) begin
      recal_next = 1'b0;
    end else if (recal_reg && step_pulse_i) begin
      if (steps_reg == STEP_W'(`RECAL_STEP_LIMIT - 1)) begin
        recal_fault = 1'b1;
        recal_next  = 1'b0;
      end
      steps_next = steps_reg + STEP_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      recal_reg <= 1'b0;
      steps_reg <= '0;
    end else begin
      recal_reg <= recal_next;
      steps_reg <= steps_next;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic [7:0]        rs0_reg, rs0_next;
  logic [7:0]        rs1_reg, rs1_next;
  logic [7:0]        rs2_reg, rs2_next;
  cmd_kind_t         kind_reg, kind_next;
  logic              cyl_differs;

  always_comb begin
    rs0_next   = rs0_reg;
    rs1_next   = rs1_reg;
    rs2_next   = rs2_reg;
    kind_next  = kind_reg;
    cyl_differs = media_evt_i.medium_cyl_valid && (media_evt_i.medium_cyl != target_cyl_i);
    // Clear first so that an event in the start cycle still sets its flag
    if (cmd_start_i) begin
      rs0_next  = `STATUS_RESET;
      rs1_next  = `STATUS_RESET;
      rs2_next  = `STATUS_RESET;
      kind_next = cmd_kind_i;
    end
    if (recal_fault) begin
      rs0_next[`RS0_TRK0_FAULT] = 1'b1;
    end
    if (cmd_end_i) begin
      rs0_next[`RS0_TERM_HI:`RS0_TERM_LO] = term_code_i;
    end
    if (seek_done_i) begin
      rs0_next[`RS0_POS_DONE] = 1'b1;
    end
    if (irq_raise_i) begin
      rs0_next[`RS0_SIDE:0] = {drive_sel_i.side, drive_sel_i.unit};
    end
    if (media_evt_i.past_last_sector) begin
      rs1_next[`RS1_PAST_LAST] = 1'b1;
    end
    if (media_evt_i.id_crc_bad || media_evt_i.data_crc_bad) begin
      rs1_next[`RS1_CRC_FAIL] = 1'b1;
    end
    if (media_evt_i.data_crc_bad) begin
      rs2_next[`RS2_DATA_CRC] = 1'b1;
    end
    if (media_evt_i.overrun) begin
      rs1_next[`RS1_OVERRUN] = 1'b1;
    end
    if (media_evt_i.sector_not_found) begin
      rs1_next[`RS1_SECTOR_ABSENT] = 1'b1;
      if (cyl_differs) begin
        rs2_next[`RS2_CYL_MISMATCH] = 1'b1;
        if (media_evt_i.medium_cyl == `BAD_CYLINDER_ID) begin
          rs2_next[`RS2_BAD_TRACK] = 1'b1;
        end
      end
    end
    if (write_protect_i && is_write_cmd(kind_reg) && !cmd_start_i) begin
      rs1_next[`RS1_WRITE_BLOCKED] = 1'b1;
    end
    if (media_evt_i.id_sync_missing) begin
      rs1_next[`RS1_ID_SYNC] = 1'b1;
    end
    if (media_evt_i.data_sync_missing) begin
      rs1_next[`RS1_ID_SYNC]   = 1'b1;
      rs2_next[`RS2_DATA_SYNC] = 1'b1;
    end
    if (media_evt_i.deleted_mark && watches_deleted(kind_reg)) begin
      rs2_next[`RS2_DELETED] = 1'b1;
    end
    if (media_evt_i.scan_equal && is_scan_cmd(kind_reg)) begin
      rs2_next[`RS2_EQUAL_HIT] = 1'b1;
    end
    if (media_evt_i.scan_no_match && is_scan_cmd(kind_reg)) begin
      rs2_next[`RS2_NO_HIT] = 1'b1;
    end
    rs0_next[`RS0_UNREADY] = 1'b0;
    rs1_next[`RS1_UNUSED_HI] = 1'b0;
    rs1_next[`RS1_UNUSED_LO] = 1'b0;
    rs2_next[`RS2_UNUSED]    = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rs0_reg   <= `STATUS_RESET;
      rs1_reg   <= `STATUS_RESET;
      rs2_reg   <= `STATUS_RESET;
      kind_reg  <= CMD_OTHER;
    end else begin
      rs0_reg   <= rs0_next;
      rs1_reg   <= rs1_next;
      rs2_reg   <= rs2_next;
      kind_reg  <= kind_next;
    end
  end

  // ****************************************
  // Drive line byte
  // ****************************************
  // Registered copy of the lines: trails the drive pins by one clock
  logic [7:0] rs3_reg, rs3_next;

  always_comb begin
    rs3_next             = `DRIVE_LINE_RESET;
    rs3_next[`RS3_WP_HI] = write_protect_i;
    rs3_next[`RS3_READY] = 1'b1;
    rs3_next[`RS3_TRK0]  = track_zero_line_i;
    rs3_next[`RS3_WP_LO] = write_protect_i;
    rs3_next[`RS3_SIDE]  = drive_sel_i.side;
    rs3_next[1:0]        = drive_sel_i.unit;
  end

  // Reset value already shows the drive as ready
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rs3_reg <= `DRIVE_LINE_RESET;
    end else begin
      rs3_reg <= rs3_next;
    end
  end

  // ****************************************
  // Result phase read-out
  // ****************************************
  typedef enum logic [0:0] {
    RES_IDLE,
    RES_SEND
  } res_state_t;

  res_state_t state_reg, state_next;
  logic [1:0] sel_reg, sel_next;
  logic [1:0] left_reg, left_next;
  logic [7:0] data_reg, data_next;
  logic       done_reg, done_next;

  function automatic logic [7:0] pick_byte(input logic [1:0] s, input logic [7:0] b0,
                                           input logic [7:0] b1, input logic [7:0] b2,
                                           input logic [7:0] b3);
    case (s)
      2'h0:    return b0;
      2'h1:    return b1;
      2'h2:    return b2;
      default: return b3;
    endcase
  endfunction : pick_byte

  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    left_next  = left_reg;
    data_next  = data_reg;
    done_next  = 1'b0;
    case (state_reg)
      RES_IDLE: begin
        if (result_start_i) begin
          state_next = RES_SEND;
          sel_next   = result_first_i;
          left_next  = result_count_i;
          data_next  = pick_byte(result_first_i, rs0_next, rs1_next, rs2_next, rs3_next);
        end
      end
      RES_SEND: begin
        // Byte is presented while direction and request are high
        if (data_rd_i) begin
          if (left_reg == 2'h0) begin
            state_next = RES_IDLE;
            done_next  = 1'b1;
          end else begin
            sel_next  = sel_reg + 2'h1;
            left_next = left_reg - 2'h1;
            data_next = pick_byte(sel_reg + 2'h1, rs0_reg, rs1_reg, rs2_reg, rs3_reg);
          end
        end
      end
      default: begin
        state_next = RES_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= RES_IDLE;
      sel_reg   <= `BYTE_SEL_RESET;
      left_reg  <= 2'h0;
      data_reg  <= `STATUS_RESET;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
      left_reg  <= left_next;
      data_reg  <= data_next;
      done_reg  <= done_next;
    end
  end

  assign data_o               = data_reg;
  assign transfer_direction_o = (state_reg == RES_SEND);
  assign host_request_flag_o  = (state_reg == RES_SEND);
  assign result_done_o        = done_reg;
  assign result_status_0_o    = rs0_reg;
  assign result_status_1_o    = rs1_reg;
  assign result_status_2_o    = rs2_reg;
  assign drive_line_status_o  = rs3_reg;

endmodule : fdc_result_status
`default_nettype wire

// ### result_status_assertions.sv
// Concurrent checks on the result status ports
`timescale 1ns/1ps
`default_nettype none
module result_status_assertions
  import result_status_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         cmd_start_i,
  input wire logic         cmd_end_i,
  input wire logic [1:0]   term_code_i,
  input wire logic         seek_done_i,
  input wire logic         irq_raise_i,
  input wire media_event_t media_evt_i,
  input wire drive_sel_t   drive_sel_i,
  input wire logic         result_start_i,
  input wire logic         write_protect_i,
  input wire logic         track_zero_line_i,
  input wire logic         transfer_direction_o,
  input wire logic         host_request_flag_o,
  input wire logic         result_done_o,
  input wire logic [7:0]   result_status_0_o,
  input wire logic [7:0]   result_status_1_o,
  input wire logic [7:0]   result_status_2_o,
  input wire logic [7:0]   drive_line_status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Checks
  // ****************************************
  a_byte3_live: assert property (
    drive_line_status_o == {1'h0, $past(write_protect_i), 1'h1, $past(track_zero_line_i),
    $past(write_protect_i), $past(drive_sel_i)}) else $error("drive line byte wrong");
  a_unused_zero: assert property (
    {result_status_1_o[6], result_status_1_o[3], result_status_2_o[7]} == 3'h0)
    else $error("unused bit set");
  a_unready_zero: assert property (result_status_0_o[3] == 1'h0)
    else $error("unready bit set");
  a_term_load: assert property (
    cmd_end_i |=> result_status_0_o[7:6] == $past(term_code_i)) else $error("term code");
  a_seek_flag: assert property (seek_done_i |=> result_status_0_o[5])
    else $error("seek flag missing");
  a_head_unit: assert property (
    irq_raise_i |=> result_status_0_o[2:0] == $past(drive_sel_i)) else $error("head unit");
  a_sync_pair: assert property (
    media_evt_i.data_sync_missing |=> result_status_1_o[0] && result_status_2_o[0])
    else $error("data mark flags");
  a_crc_flag: assert property (
    media_evt_i.data_crc_bad |=> result_status_1_o[5] && result_status_2_o[5])
    else $error("crc flags");
  a_start_clear: assert property (
    cmd_start_i && media_evt_i == '0 && !write_protect_i && !seek_done_i
    |=> result_status_1_o == 8'h00 && result_status_2_o == 8'h00 && !result_status_0_o[5])
    else $error("flags not cleared");
  a_req_rise: assert property (
    result_start_i && !host_request_flag_o |=> host_request_flag_o && transfer_direction_o)
    else $error("request flag late");
  a_done_idle: assert property (result_done_o |-> !host_request_flag_o)
    else $error("done while requesting");
endmodule : result_status_assertions
bind fdc_result_status result_status_assertions chk (.*);
`default_nettype wire

// ### host_reader.sv
// Host side model that empties the data register in the result phase
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input wire logic        clk_i,
  input wire logic        hold_i,
  input wire logic        request_flag_i,
  input wire logic        direction_i,
  input wire logic [7:0]  data_i,
  output logic            rd_o,
  output logic            got_o,
  output logic [7:0]      byte_o
);
  initial begin
    rd_o = 1'h0;
    got_o = 1'h0;
    byte_o = 8'h00;
  end
  // Reads only while both flags say so; may stall on hold_i
  always @(posedge clk_i) begin
    got_o <= rd_o && request_flag_i;
    byte_o <= data_i;
    rd_o <= request_flag_i && direction_i && !hold_i;
  end
endmodule : host_reader
`default_nettype wire

// ### fdc_result_status_tb_top.sv
// Self-checking bench for the result status logic
`timescale 1ns/1ps
`default_nettype none
module fdc_result_status_tb_top;
  import result_status_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, hold = 1'h0, got, data_rd_i;
  logic cmd_start_i = 1'h0, cmd_end_i = 1'h0, seek_done_i = 1'h0, recal_start_i = 1'h0;
  logic step_pulse_i = 1'h0, irq_raise_i = 1'h0, result_start_i = 1'h0;
  logic write_protect_i = 1'h0, track_zero_line_i = 1'h0;
  logic transfer_direction_o, host_request_flag_o, result_done_o;
  logic [1:0] term_code_i = 2'h0, result_first_i = 2'h0, result_count_i = 2'h3;
  logic [7:0] target_cyl_i = 8'h00, data_o, got_byte;
  cmd_kind_t cmd_kind_i = CMD_OTHER;
  media_event_t media_evt_i = '0;
  drive_sel_t drive_sel_i = '0;
  logic [7:0] exp_q[$];
  int num_errors = 0, n_tests = 0, seed = 11;

  fdc_result_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_start_i(cmd_start_i),
    .cmd_kind_i(cmd_kind_i), .cmd_end_i(cmd_end_i), .term_code_i(term_code_i),
    .seek_done_i(seek_done_i), .recal_start_i(recal_start_i), .step_pulse_i(step_pulse_i),
    .irq_raise_i(irq_raise_i), .media_evt_i(media_evt_i), .target_cyl_i(target_cyl_i),
    .drive_sel_i(drive_sel_i), .result_start_i(result_start_i),
    .result_first_i(result_first_i), .result_count_i(result_count_i), .data_rd_i(data_rd_i),
    .data_o(data_o), .transfer_direction_o(transfer_direction_o),
    .host_request_flag_o(host_request_flag_o), .result_done_o(result_done_o),
    .write_protect_i(write_protect_i), .track_zero_line_i(track_zero_line_i),
    .result_status_0_o(), .result_status_1_o(), .result_status_2_o(),
    .drive_line_status_o());
  host_reader host (.clk_i(clk_i), .hold_i(hold), .request_flag_i(host_request_flag_o),
    .direction_i(transfer_direction_o), .data_i(data_o), .rd_o(data_rd_i), .got_o(got),
    .byte_o(got_byte));

  initial forever #20 clk_i = ~clk_i;
  always @(negedge clk_i) hold <= 1'($random(seed));
  always @(negedge clk_i) if (got === 1'h1) check(got_byte, exp_q.pop_front());

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ****************************************
  // One command: event j, kind k, then a wrapped read-out of a random byte count
  // ****************************************
  task automatic run(input int j, input int k);
    media_event_t ev;
    drive_sel_t sel;
    cmd_kind_t kd;
    logic [1:0] tc, f, c;
    logic [7:0] tg, e[4];
    logic sk, wp, tz, w, sc, mm;
    int ns, n;
    kd = cmd_kind_t'(k);
    ev = '0;
    ev[8 + (j % 11)] = 1'h1;
    if (j == 6 || j == 11) ev.medium_cyl_valid = 1'h1;
    if (j == 11) ev.sector_not_found = 1'h1;
    ev.medium_cyl = (j == 11) ? 8'hFF : 8'($random(seed));
    tg = {1'h0, 7'($random(seed))};
    sel = 3'($random(seed));
    tc = 2'($unsigned($random(seed)) % 3);
    {sk, wp, tz} = 3'($random(seed));
    f = 2'($random(seed));
    c = 2'($random(seed));
    if (k == 0) tz = (j % 4 == 3);
    ns = (k == 0) ? 76 + j % 2 : 0;
    cmd_start_i = 1'h1;
    cmd_kind_i = kd;
    target_cyl_i = tg;
    @(negedge clk_i);
    cmd_start_i = 1'h0;
    write_protect_i = wp;
    track_zero_line_i = tz;
    drive_sel_i = sel;
    recal_start_i = (ns > 0);
    @(negedge clk_i);
    recal_start_i = 1'h0;
    repeat (2 * ns) begin
      step_pulse_i = ~step_pulse_i;
      @(negedge clk_i);
    end
    media_evt_i = ev;
    seek_done_i = sk;
    @(negedge clk_i);
    media_evt_i = '0;
    seek_done_i = 1'h0;
    cmd_end_i = 1'h1;
    term_code_i = tc;
    @(negedge clk_i);
    cmd_end_i = 1'h0;
    irq_raise_i = 1'h1;
    @(negedge clk_i);
    irq_raise_i = 1'h0;
    w = kd inside {CMD_WRITE_DATA, CMD_WRITE_DELETED, CMD_FORMAT_TRACK};
    sc = (kd == CMD_SCAN);
    mm = ev.sector_not_found & ev.medium_cyl_valid & (ev.medium_cyl != tg);
    e[0] = {tc, sk, (ns > 76) & !tz, 1'h0, sel};
    e[1] = {ev.past_last_sector, 1'h0, ev.id_crc_bad | ev.data_crc_bad, ev.overrun, 1'h0,
            ev.sector_not_found, wp & w, ev.id_sync_missing | ev.data_sync_missing};
    e[2] = {1'h0, ev.deleted_mark & (sc | (kd == CMD_READ_DATA)), ev.data_crc_bad, mm,
            ev.scan_equal & sc, ev.scan_no_match & sc, mm & (ev.medium_cyl == 8'hFF),
            ev.data_sync_missing};
    e[3] = {1'h0, wp, 1'h1, tz, wp, sel};
    for (n = 0; n <= c; n++) exp_q.push_back(e[2'(f + n)]);
    result_first_i = f;
    result_count_i = c;
    result_start_i = 1'h1;
    @(negedge clk_i);
    result_start_i = 1'h0;
    for (n = 0; n < 60 && result_done_o !== 1'h1; n++) @(negedge clk_i);
    if (n == 60) num_errors++;
    write_protect_i = 1'h0;
    repeat (2) @(negedge clk_i);
  endtask : run

  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'h1;
    repeat (3) @(negedge clk_i);
    for (int j = 0; j < 12; j++) begin
      for (int k = 0; k < 8; k++) run(j, k);
    end
    results();
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #1000000;
    num_errors++;
    results();
  end
endmodule : fdc_result_status_tb_top
`default_nettype wire
